//--- verilog/bsh_pkg.sv
// shared constants for the circular barrel shifter
`default_nettype none
package bsh_pkg;
  localparam int unsigned DATA_W      = 18;
  localparam int unsigned ACC_W       = 48;
  localparam int unsigned PROD_W      = 2 * DATA_W;
  localparam int unsigned CASC_SHIFT  = 17;
  localparam int unsigned SIGN_BIT    = DATA_W - 1;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned OPSEL_W     = 8;
  localparam int unsigned OPSEL_SUB   = 7;
  localparam int unsigned OPSEL_ZCASC = 2;
  // x = product, z = zero
  localparam logic [6:0]  OPSEL_MUL   = 7'h01;
  // x = product, z = cascade input
  localparam logic [6:0]  OPSEL_MADD  = 7'h05;
  localparam logic [ACC_W-1:0]  ACC_ZERO  = 48'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0;
endpackage : bsh_pkg
`default_nettype wire

//--- verilog/bsh_stage_if.sv
// carrier between the pipeline and one multiply-add stage
`default_nettype none
interface bsh_stage_if;
  import bsh_pkg::*;
  logic                 en;
  logic [DATA_W-1:0]    a;
  logic [DATA_W-1:0]    b;
  logic [OPSEL_W-1:0]   operation_select;
  logic [ACC_W-1:0]     cascade_input;
  logic [ACC_W-1:0]     p;
  modport ctrl  (output en, a, b, operation_select, cascade_input, input p);
  modport stage (input en, a, b, operation_select, cascade_input, output p);
endinterface : bsh_stage_if
`default_nettype wire

//--- verilog/bsh_stage.sv
// one multiply-add stage: registered product, subtract pipeline, result register
`default_nettype none
module bsh_stage
  import bsh_pkg::*;
(
  // clock and reset
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  // operands and result
  bsh_stage_if.stage  s
);
  typedef struct packed {
    logic [ACC_W-1:0] m;
    logic             sub;
    logic             zcasc;
    logic [ACC_W-1:0] p;
  } bsh_stage_t;

  bsh_stage_t st_reg;
  bsh_stage_t st_next;
  logic signed [PROD_W-1:0] prod;

  ////////////////////////////////////////////////////////////////////////////
  assign prod = $signed(s.a) * $signed(s.b);

  always_comb begin
    st_next = st_reg;
    if (s.en) begin
      st_next.m     = {{(ACC_W - PROD_W){prod[PROD_W-1]}}, prod};
      // subtract control registered alongside the product
      st_next.sub   = s.operation_select[OPSEL_SUB];
      st_next.zcasc = s.operation_select[OPSEL_ZCASC];
      // a negative factor is undone by subtracting the product
      if (st_reg.sub) begin
        st_next.p = (st_reg.zcasc ? s.cascade_input : ACC_ZERO) - st_reg.m;
      end else begin
        st_next.p = (st_reg.zcasc ? s.cascade_input : ACC_ZERO) + st_reg.m;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s.p = st_reg.p;
endmodule : bsh_stage
`default_nettype wire

//--- verilog/bsh_fifo.sv
// result buffer: flip-flop fifo with valid/ready on both sides
`default_nettype none
module bsh_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr;
    logic [PTR_W-1:0]            rd;
    logic [CNT_W-1:0]            cnt;
  } bsh_fifo_t;

  bsh_fifo_t st_reg;
  bsh_fifo_t st_next;
  logic      push;
  logic      pop;

  ////////////////////////////////////////////////////////////////////////////
  assign o_in_ready  = (st_reg.cnt != CNT_FULL);
  assign o_out_valid = (st_reg.cnt != '0);
  assign o_out_data  = st_reg.mem[st_reg.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = i_in_data;
      st_next.wr = (st_reg.wr == PTR_LAST) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == PTR_LAST) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : bsh_fifo
`default_nettype wire

//--- verilog/bsh_top.sv
// dynamic 18-bit circular barrel shifter built from two multiply-add stages
//
// Behaviour
// - rotate 18-bit operand left by n
// - two cascaded stages, fixed shifts by wiring
// - stage one holds zeros, data[17:1], n zeros
// - cascade carries stage one shifted right 17
// - stage two adds top bits to shifted operand
// - new operand and result every cycle
// - n=17 negative factor undone by subtracting
// - operation select top bit means subtract
`default_nettype none
module bsh_top
  import bsh_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // operand stream from upstream logic
  input  wire logic              i_valid,
  output logic                   o_ready,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic [DATA_W-1:0] i_scale,
  // rotated result stream
  output logic                   o_valid,
  input  wire logic              i_ready,
  output logic [DATA_W-1:0]      o_result
);
  typedef struct packed {
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] scale_q;
    logic              sign_delay_first;
    logic [DATA_W-1:0] data_q1;
    logic [DATA_W-1:0] scale_q1;
    logic              sign_delay_second;
    // one valid bit per pipeline edge: input, product, lower result, upper result
    logic [3:0]        vld;
  } bsh_pipe_t;

  bsh_pipe_t st_reg;
  bsh_pipe_t st_next;
  logic      adv;
  logic      res_vld;

  bsh_stage_if lower ();
  bsh_stage_if upper ();

  ////////////////////////////////////////////////////////////////////////////
  // whole pipeline moves together; it stalls only when the buffer is full
  assign o_ready = adv;

  always_comb begin
    st_next = st_reg;
    if (adv) begin
      st_next.data_q            = i_valid ? i_data : DATA_ZERO;
      // scale is two to n; n=17 shows up as the sign bit
      st_next.scale_q           = i_valid ? i_scale : DATA_ZERO;
      st_next.sign_delay_first  = i_valid && i_scale[SIGN_BIT];
      st_next.data_q1           = st_reg.data_q;
      st_next.scale_q1          = st_reg.scale_q;
      st_next.sign_delay_second = st_reg.sign_delay_first;
      st_next.vld               = {st_reg.vld[2:0], i_valid};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lower stage: positive 0,data[17:1] times 2^n into a zero accumulator
  assign lower.en               = adv;
  assign lower.a                = {1'b0, st_reg.data_q[DATA_W-1:1]};
  assign lower.b                = st_reg.scale_q;
  assign lower.operation_select = {st_reg.sign_delay_first, OPSEL_MUL};
  assign lower.cascade_input    = ACC_ZERO;

  bsh_stage u_lower (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .s          (lower)
  );

  // upper stage: the wire shift leaves only the n top operand bits
  assign upper.en               = adv;
  assign upper.a                = st_reg.data_q1;
  assign upper.b                = st_reg.scale_q1;
  assign upper.operation_select = {st_reg.sign_delay_second, OPSEL_MADD};
  assign upper.cascade_input    = lower.p >> CASC_SHIFT;

  bsh_stage u_upper (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .s          (upper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // low 18 bits of the upper result are the rotated operand; bits above are junk
  // the upper result register settles one edge after the third valid bit; pushing
  // on vld[2] would store the previous operand's rotation
  assign res_vld = st_reg.vld[3];

  bsh_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_in_valid  (res_vld),
    .o_in_ready  (adv),
    .i_in_data   (upper.p[DATA_W-1:0]),
    .o_out_valid (o_valid),
    .i_out_ready (i_ready),
    .o_out_data  (o_result)
  );
endmodule : bsh_top
`default_nettype wire

//--- verification/bsh_top_monitor.sv
// port assertions for the barrel shifter top
`default_nettype none
module bsh_top_monitor
  import bsh_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // top ports
  input wire logic              i_core_clk,
  input wire logic              i_rst,
  input wire logic              i_valid,
  input wire logic              o_ready,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] i_scale,
  input wire logic              o_valid,
  input wire logic              i_ready,
  input wire logic [DATA_W-1:0] o_result
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // product halves folded together give the rotation for a power-of-two scale
  function automatic logic [17:0] rot(logic [17:0] d, logic [17:0] s);
    logic [35:0] p;
    p = {18'h0, d} * {18'h0, s};
    return p[17:0] | p[35:18];
  endfunction : rot
  ////////////////////////////////////////
  chk_reset_idle: assert property (disable iff (1'b0)
    i_rst |=> !o_valid && o_ready) else $error("not idle after reset");
  chk_first_delay: assert property ($rose(o_valid) |-> $past(i_valid && o_ready, 5))
    else $error("result without take 5 edges before");
  chk_first_value: assert property (
    $rose(o_valid) |-> o_result == rot($past(i_data, 5), $past(i_scale, 5)))
    else $error("wrong rotation");
  chk_rot_zero: assert property (
    $rose(o_valid) && $past(i_scale, 5) == 18'h00001 |-> o_result == $past(i_data, 5))
    else $error("zero shift altered data");
  chk_rot_top: assert property (
    $rose(o_valid) && $past(i_scale, 5) == 18'h20000 |->
    o_result == {$past(i_data[0], 5), $past(i_data[17:1], 5)}) else $error("shift 17 wrong");
  chk_hold_result: assert property (
    o_valid && !i_ready |=> o_valid && $stable(o_result)) else $error("result not held");
  chk_empty_ready: assert property (!o_valid |-> o_ready) else $error("refused while empty");
  chk_full_release: assert property (!o_ready && i_ready |=> o_ready)
    else $error("still full after take");
  cov_full: cover property (!o_ready);
  cov_top: cover property (i_valid && o_ready && i_scale == 18'h20000);
  cov_b2b: cover property (i_valid && o_ready ##1 i_valid && o_ready);
endmodule : bsh_top_monitor
bind bsh_top bsh_top_monitor #(.DEPTH(DEPTH)) u_bsh_top_monitor (.i_core_clk, .i_rst,
  .i_valid, .o_ready, .i_data, .i_scale, .o_valid, .i_ready, .o_result);
`default_nettype wire

//--- verification/bsh_src.sv
// upstream model: operand source giving the shift as a power of two
`default_nettype none
module bsh_src
  import bsh_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_go,
  input  wire logic [DATA_W-1:0] i_d,
  input  wire logic [4:0]        i_n,
  output logic                   o_valid,
  output logic [DATA_W-1:0]      o_data,
  output logic [DATA_W-1:0]      o_scale
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] last_reg = 18'h15555;
  // idle lines show junk, so a stale operand never looks valid
  always @(posedge i_core_clk) if (i_go) last_reg <= i_d;
  assign o_valid = i_go;
  assign o_data  = i_go ? i_d : ~last_reg;
  assign o_scale = i_go ? 18'h1 << i_n : ~last_reg;
endmodule : bsh_src
`default_nettype wire

//--- verification/bsh_top_tb_top.sv
// self-checking bench for the barrel shifter
`default_nettype none
module bsh_top_tb_top;
  import bsh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              i_core_clk, i_rst, i_valid, o_ready, o_valid, i_ready, go;
  logic [DATA_W-1:0] i_data, i_scale, o_result, dd;
  logic [4:0]        nn;
  logic [DATA_W-1:0] exp_q[$];
  int                num_errors, n_checks;
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  bsh_src u_bsh_src (.i_core_clk, .i_go(go), .i_d(dd), .i_n(nn), .o_valid(i_valid),
    .o_data(i_data), .o_scale(i_scale));
  bsh_top #(.DEPTH(FIFO_DEPTH)) u_bsh_top (.i_core_clk, .i_rst, .i_valid, .o_ready,
    .i_data, .i_scale, .o_valid, .i_ready, .o_result);
  ////////////////////////////////////////
  function automatic logic [17:0] rot(logic [17:0] d, logic [4:0] n);
    logic [35:0] w;
    w = {d, d} << n;
    return w[35:18];
  endfunction : rot
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  always @(posedge i_core_clk) begin
    if (i_rst) exp_q.delete();
    else begin
      if (o_valid && i_ready) chk(o_result, exp_q.pop_front());
      if (i_valid && o_ready) exp_q.push_back(rot(i_data, nn));
    end
  end
  task automatic send(input logic [17:0] d, input int n);
    go <= 1'b1;
    dd <= d;
    nn <= 5'(n);
    do @(posedge i_core_clk); while (!o_ready);
  endtask : send
  task automatic idle(input int c);
    go <= 1'b0;
    repeat (c) @(posedge i_core_clk);
  endtask : idle
  task automatic drain();
    i_ready <= 1'b1;
    idle(1);
    for (int k = 0; k < 60 && exp_q.size() > 0; k++) @(posedge i_core_clk);
    chk(18'(exp_q.size()), 18'h0);
  endtask : drain
  ////////////////////////////////////////
  task automatic t_sweep();
    i_ready <= 1'b1;
    for (int n = 0; n < 18; n++) send(18'h2b4c7 + 18'(n * 97), n);
    drain();
  endtask : t_sweep
  task automatic t_full();
    i_ready <= 1'b0;
    for (int k = 0; k < 40 && o_ready; k++) begin
      go <= 1'b1;
      dd <= 18'h3ffff - 18'(k * 33);
      nn <= 5'(17 - k % 18);
      @(posedge i_core_clk);
    end
    chk(18'(o_ready), 18'h0);
    chk(18'(exp_q.size() > FIFO_DEPTH), 18'h1);
    idle(3);
    for (int k = 0; k < 40; k++) begin
      i_ready <= k[0];
      @(posedge i_core_clk);
    end
    drain();
  endtask : t_full
  task automatic t_sign();
    // n=17 beside small shifts shakes out misaligned sign delays
    i_ready <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      send(18'h20001 + 18'(k * 4099), (k % 3 == 0) ? 17 : k % 2);
      if (k % 4 == 3) idle(1);
    end
    drain();
  endtask : t_sign
  task automatic t_reset();
    for (int k = 0; k < 3; k++) send(18'h1e0f0 + 18'(k), k + 5);
    idle(1);
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    idle(6);
    chk(18'({o_valid, o_ready}), 18'h1);
  endtask : t_reset
  initial begin
    i_rst = 1'b1;
    go = 1'b0;
    dd = 18'h0;
    nn = 5'h0;
    i_ready = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    idle(2);
    t_sweep();
    t_full();
    t_sign();
    t_reset();
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge i_core_clk);
    num_errors++;
    finish_test();
  end
endmodule : bsh_top_tb_top
`default_nettype wire
